// *** hdl/video_port_config.sv ***
// video port configuration registers and output formatter
// Function
// - gain bypass bit routes sampler output straight to the converter
// - amplifier power-down bit powers down the gain amplifier
// - converter power-down bit powers down the converter
// - divisor field divides master clock; zero means undivided
// - bus width field picks 12, 10 or 8 top lines; rest float
// - routing field shifts converter bits toward the bus top
// - gating bit makes pixel clock run only with valid data
// - frame sync shape bit selects end pulse instead of frame level
// - line sync shape bit gives four-clock pulse at row end
// - edge bit makes falling pixel clock edge the active edge
// - frame polarity bit inverts level; pulse is always negative
// - line polarity bit inverts level; pulse is always negative
// - field bit turns frame sync into odd/even field indicator
// - float bit releases every data and control output
// - lead field starts line sync 0 to 15 clocks before pixels
`timescale 1ns/100ps
module video_port_config (
    input  wire logic                     core_clk_in,
    input  wire logic                     arst_n_in,
    input  wire logic                     mclk_in,
    input  wire logic [7:0]               reg_addr_in,
    input  wire logic [7:0]               reg_wdata_in,
    input  wire logic                     reg_wr_in,
    output logic      [7:0]               reg_rdata_out,
    output logic                          gain_bypass_out,
    output logic                          amplifier_powerdown_out,
    output logic                          converter_powerdown_out,
    output logic                          pixel_tick_out,
    input  wire logic [video_port_pkg::PIX_W-1:0] adc_data_in,
    input  wire logic                     pix_valid_in,
    input  wire logic                     row_active_in,
    input  wire logic                     frame_active_in,
    input  wire logic                     field_odd_in,
    output logic [video_port_pkg::PIX_W-1:0] video_data_out,
    output logic [video_port_pkg::PIX_W-1:0] video_data_oe_out,
    output logic                          pclk_out,
    output logic                          pclk_oe_out,
    output logic                          frame_sync_out,
    output logic                          frame_sync_oe_out,
    output logic                          line_sync_out,
    output logic                          line_sync_oe_out
);
    import video_port_pkg::*;

    logic [7:0]             power_reg;
    logic [7:0]             divider_reg;
    logic [7:0]             format_reg;
    logic [7:0]             sync_reg;
    logic [7:0]             lead_reg;
    logic                   sensor_tick;
    logic                   phase_reg;
    logic                   half_tick_reg;
    logic                   out_valid_reg;
    logic                   line_prev_reg;
    logic                   frame_prev_reg;
    logic [PULSE_CNT_W-1:0] lcnt_reg;
    logic [PULSE_CNT_W-1:0] fcnt_reg;
    logic [PULSE_CNT_W-1:0] lcnt_next;
    logic [PULSE_CNT_W-1:0] fcnt_next;
    logic [PKT_W-1:0]       taps [LEAD_DEPTH];

    // ---------------------------------------------------------------
    // register decode
    // ---------------------------------------------------------------
    wire       wr_power   = reg_wr_in & (reg_addr_in == ADDR_POWER);
    wire       wr_divider = reg_wr_in & (reg_addr_in == ADDR_DIVIDER);
    wire       wr_format  = reg_wr_in & (reg_addr_in == ADDR_FORMAT);
    wire       wr_sync    = reg_wr_in & (reg_addr_in == ADDR_SYNC);
    wire       wr_lead    = reg_wr_in & (reg_addr_in == ADDR_LEAD);
    wire [7:0] rd_value   =
        (reg_addr_in == ADDR_POWER)   ? power_reg   :
        (reg_addr_in == ADDR_DIVIDER) ? divider_reg :
        (reg_addr_in == ADDR_FORMAT)  ? format_reg  :
        (reg_addr_in == ADDR_SYNC)    ? sync_reg    :
        (reg_addr_in == ADDR_LEAD)    ? lead_reg    : READ_UNMAPPED;

    always_ff @(posedge core_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            power_reg     <= RST_POWER;
            divider_reg   <= RST_DIVIDER;
            format_reg    <= RST_FORMAT;
            sync_reg      <= RST_SYNC;
            lead_reg      <= RST_LEAD;
            reg_rdata_out <= READ_UNMAPPED;
        end else begin
            if (wr_power)   power_reg   <= reg_wdata_in & MASK_POWER;
            if (wr_divider) divider_reg <= reg_wdata_in;
            if (wr_format)  format_reg  <= reg_wdata_in & MASK_FORMAT;
            if (wr_sync)    sync_reg    <= reg_wdata_in;
            if (wr_lead)    lead_reg    <= reg_wdata_in & MASK_LEAD;
            reg_rdata_out <= rd_value;
        end
    end

    // ---------------------------------------------------------------
    // analog front-end controls
    // ---------------------------------------------------------------
    always_ff @(posedge core_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            gain_bypass_out         <= 1'b0;
            amplifier_powerdown_out <= 1'b0;
            converter_powerdown_out <= 1'b0;
        end else begin
            gain_bypass_out         <= power_reg[BIT_GAIN_BYPASS];
            amplifier_powerdown_out <= power_reg[BIT_AMP_PWDN];
            converter_powerdown_out <= power_reg[BIT_ADC_PWDN];
        end
    end

    // ---------------------------------------------------------------
    // sensor clock and pixel slots
    // ---------------------------------------------------------------
    sensor_clock_gen u_clock_gen (
        .core_clk_in     (core_clk_in),
        .arst_n_in       (arst_n_in),
        .mclk_in         (mclk_in),
        .divisor_in      (divider_reg),
        .sensor_tick_out (sensor_tick)
    );

    // one pixel per two sensor ticks: data edge, then active edge
    always_ff @(posedge core_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            phase_reg      <= 1'b0;
            pixel_tick_out <= 1'b0;
            half_tick_reg  <= 1'b0;
        end else begin
            if (sensor_tick) phase_reg <= ~phase_reg;
            pixel_tick_out <= sensor_tick & ~phase_reg;
            half_tick_reg  <= sensor_tick & phase_reg;
        end
    end

    wire [PKT_W-1:0] in_pkt = {field_odd_in, frame_active_in,
                               row_active_in, pix_valid_in, adc_data_in};

    pixel_delay_line #(
        .WIDTH (PKT_W),
        .DEPTH (LEAD_DEPTH)
    ) u_delay (
        .core_clk_in (core_clk_in),
        .arst_n_in   (arst_n_in),
        .shift_in    (pixel_tick_out),
        .data_in     (in_pkt),
        .taps_out    (taps)
    );

    // ---------------------------------------------------------------
    // field decode
    // ---------------------------------------------------------------
    wire [1:0]       width_sel  = format_reg[WIDTH_HI:WIDTH_LO];
    wire [1:0]       msb_route  = format_reg[ROUTE_HI:ROUTE_LO];
    wire [3:0]       lead_count = lead_reg[LEAD_HI:LEAD_LO];
    wire             clk_gating = sync_reg[BIT_PCLK_GATING];
    wire             fs_shape   = sync_reg[BIT_FSYNC_SHAPE];
    wire             ls_shape   = sync_reg[BIT_LSYNC_SHAPE];
    wire             clk_edge   = sync_reg[BIT_PCLK_EDGE];
    wire             fs_pol     = sync_reg[BIT_FSYNC_POL];
    wire             ls_pol     = sync_reg[BIT_LSYNC_POL];
    wire             field_en   = sync_reg[BIT_FIELD_EN];
    wire             port_float = sync_reg[BIT_PORT_FLOAT];

    // ---------------------------------------------------------------
    // data formatting
    // ---------------------------------------------------------------
    wire [PKT_W-1:0] out_pkt    = taps[LEAD_LAST];
    wire [3:0]       lead_idx   = 4'(LEAD_LAST - lead_count);
    wire [PKT_W-1:0] lead_pkt   = taps[lead_idx];
    wire [PIX_W-1:0] out_pix    = out_pkt[PIX_W-1:0];
    wire [PIX_W-1:0] routed_pix = out_pix << msb_route;
    // reserved width code keeps all twelve lines
    wire [3:0]       low_line   =
        (width_sel == WIDTH_10) ? LOW_LINE_10 :
        (width_sel == WIDTH_8)  ? LOW_LINE_8  : LOW_LINE_12;
    wire [PIX_W-1:0] line_mask  = ALL_LINES << low_line;
    wire [PIX_W-1:0] data_oe    = port_float ? NO_LINES : line_mask;

    // ---------------------------------------------------------------
    // sync shaping
    // ---------------------------------------------------------------
    // level is stretched forward by the lead, ends with the row
    wire line_act  = lead_pkt[PKT_ROW] | out_pkt[PKT_ROW];
    wire frame_act = out_pkt[PKT_FRAME];
    wire line_end  = line_prev_reg & ~line_act;
    wire frame_end = frame_prev_reg & ~frame_act;

    always_comb begin
        lcnt_next = lcnt_reg;
        fcnt_next = fcnt_reg;
        if (line_end) begin
            lcnt_next = LSYNC_PULSE;
        end else if (lcnt_reg != '0) begin
            lcnt_next = lcnt_reg - 1'b1;
        end
        if (frame_end) begin
            fcnt_next = FSYNC_PULSE;
        end else if (fcnt_reg != '0) begin
            fcnt_next = fcnt_reg - 1'b1;
        end
    end

    wire line_level  = line_act ^ ls_pol;
    wire frame_level = frame_act ^ fs_pol;
    wire line_value  = ls_shape ? (lcnt_next == '0) : line_level;
    wire frame_shape = fs_shape ? (fcnt_next == '0) : frame_level;
    wire frame_value = field_en ? out_pkt[PKT_FIELD] : frame_shape;
    // gated clock stays parked at its idle level between valid pixels
    wire clk_run     = ~clk_gating | out_valid_reg;

    // ---------------------------------------------------------------
    // output registers
    // ---------------------------------------------------------------
    always_ff @(posedge core_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            video_data_out <= NO_LINES;
            out_valid_reg  <= 1'b0;
            line_prev_reg  <= 1'b0;
            frame_prev_reg <= 1'b0;
            lcnt_reg       <= '0;
            fcnt_reg       <= '0;
            line_sync_out  <= 1'b1;
            frame_sync_out <= 1'b1;
        end else if (pixel_tick_out) begin
            video_data_out <= routed_pix;
            out_valid_reg  <= out_pkt[PKT_VALID];
            line_prev_reg  <= line_act;
            frame_prev_reg <= frame_act;
            lcnt_reg       <= lcnt_next;
            fcnt_reg       <= fcnt_next;
            line_sync_out  <= line_value;
            frame_sync_out <= frame_value;
        end
    end

    // data changes with the idle-going transition
    always_ff @(posedge core_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            pclk_out <= 1'b0;
        end else if (pixel_tick_out) begin
            pclk_out <= clk_edge;
        end else if (half_tick_reg) begin
            pclk_out <= clk_run ? ~clk_edge : clk_edge;
        end
    end

    // float acts at once, not at the next pixel slot
    always_ff @(posedge core_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            video_data_oe_out <= NO_LINES;
            pclk_oe_out       <= 1'b0;
            frame_sync_oe_out <= 1'b0;
            line_sync_oe_out  <= 1'b0;
        end else begin
            video_data_oe_out <= data_oe;
            pclk_oe_out       <= ~port_float;
            frame_sync_oe_out <= ~port_float;
            line_sync_oe_out  <= ~port_float;
        end
    end

    // ---------------------------------------------------------------
    // checks
    // ---------------------------------------------------------------
    a_bypass_write: assert property (@(posedge core_clk_in)
        disable iff (!arst_n_in)
        wr_power |=> ##1 gain_bypass_out == $past(reg_wdata_in[7], 2))
        else $error("gain bypass did not follow write");
    a_amp_pwdn_write: assert property (@(posedge core_clk_in)
        disable iff (!arst_n_in)
        wr_power |=> ##1
            amplifier_powerdown_out == $past(reg_wdata_in[3], 2))
        else $error("amplifier power-down did not follow write");
    a_adc_pwdn_write: assert property (@(posedge core_clk_in)
        disable iff (!arst_n_in)
        wr_power |=> ##1
            converter_powerdown_out == $past(reg_wdata_in[0], 2))
        else $error("converter power-down did not follow write");
    a_width_ten: assert property (@(posedge core_clk_in)
        disable iff (!arst_n_in)
        (!port_float && width_sel == WIDTH_10) |=>
            video_data_oe_out == 12'hFFC)
        else $error("ten line mode drives wrong lines");
    a_route_one: assert property (@(posedge core_clk_in)
        disable iff (!arst_n_in)
        (pixel_tick_out && msb_route == 2'h1) |=>
            video_data_out == {$past(out_pix[10:0]), 1'b0})
        else $error("routing by one is wrong");
    a_gated_idle: assert property (@(posedge core_clk_in)
        disable iff (!arst_n_in)
        (half_tick_reg && clk_gating && !out_valid_reg && !pixel_tick_out)
            |=> pclk_out == $past(clk_edge))
        else $error("gated pixel clock toggled without data");
    a_line_pulse: assert property (@(posedge core_clk_in)
        disable iff (!arst_n_in)
        (pixel_tick_out && ls_shape && line_end) |=> !line_sync_out)
        else $error("line pulse missing at row end");
    a_frame_pulse: assert property (@(posedge core_clk_in)
        disable iff (!arst_n_in)
        (pixel_tick_out && fs_shape && !field_en && frame_end)
            |=> !frame_sync_out)
        else $error("frame pulse missing at frame end");
    a_active_edge: assert property (@(posedge core_clk_in)
        disable iff (!arst_n_in)
        (half_tick_reg && !clk_gating) |=> pclk_out == !$past(clk_edge))
        else $error("pixel clock active edge wrong");
    a_field_show: assert property (@(posedge core_clk_in)
        disable iff (!arst_n_in)
        (pixel_tick_out && field_en) |=>
            frame_sync_out == $past(out_pkt[PKT_FIELD]))
        else $error("field indicator not shown");
    a_float_all: assert property (@(posedge core_clk_in)
        disable iff (!arst_n_in)
        port_float |=> (video_data_oe_out == NO_LINES) && !pclk_oe_out
            && !frame_sync_oe_out && !line_sync_oe_out)
        else $error("port float left a driver on");
    a_lead_level: assert property (@(posedge core_clk_in)
        disable iff (!arst_n_in)
        (pixel_tick_out && !ls_shape && lead_pkt[PKT_ROW]) |=>
            line_sync_out == !$past(ls_pol))
        else $error("line sync lead edge late");
endmodule // video_port_config

// *** hdl/video_port_pkg.sv ***
// shared constants for the video port configuration block
package video_port_pkg;
    // ---------------------------------------------------------------
    // register map
    // ---------------------------------------------------------------
    localparam int          REG_W          = 8;
    localparam logic [7:0]  ADDR_POWER     = 8'h04;
    localparam logic [7:0]  ADDR_DIVIDER   = 8'h05;
    localparam logic [7:0]  ADDR_FORMAT    = 8'h06;
    localparam logic [7:0]  ADDR_SYNC      = 8'h07;
    localparam logic [7:0]  ADDR_LEAD      = 8'h08;
    localparam logic [7:0]  RST_POWER      = 8'h00;
    localparam logic [7:0]  RST_DIVIDER    = 8'h04;
    localparam logic [7:0]  RST_FORMAT     = 8'h00;
    localparam logic [7:0]  RST_SYNC       = 8'h00;
    localparam logic [7:0]  RST_LEAD       = 8'h00;
    // reserved bits are not stored and read as zero
    localparam logic [7:0]  MASK_POWER     = 8'h89;
    localparam logic [7:0]  MASK_FORMAT    = 8'hF0;
    localparam logic [7:0]  MASK_LEAD      = 8'hF0;
    localparam logic [7:0]  READ_UNMAPPED  = 8'h00;
    // ---------------------------------------------------------------
    // field positions
    // ---------------------------------------------------------------
    localparam int BIT_GAIN_BYPASS   = 7;
    localparam int BIT_AMP_PWDN      = 3;
    localparam int BIT_ADC_PWDN      = 0;
    localparam int WIDTH_HI          = 7;
    localparam int WIDTH_LO          = 6;
    localparam int ROUTE_HI          = 5;
    localparam int ROUTE_LO          = 4;
    localparam int BIT_PCLK_GATING   = 7;
    localparam int BIT_FSYNC_SHAPE   = 6;
    localparam int BIT_LSYNC_SHAPE   = 5;
    localparam int BIT_PCLK_EDGE     = 4;
    localparam int BIT_FSYNC_POL     = 3;
    localparam int BIT_LSYNC_POL     = 2;
    localparam int BIT_FIELD_EN      = 1;
    localparam int BIT_PORT_FLOAT    = 0;
    localparam int LEAD_HI           = 7;
    localparam int LEAD_LO           = 4;
    // ---------------------------------------------------------------
    // bus width codes and low active line
    // ---------------------------------------------------------------
    localparam logic [1:0]  WIDTH_12       = 2'h0;
    localparam logic [1:0]  WIDTH_10       = 2'h1;
    localparam logic [1:0]  WIDTH_8        = 2'h2;
    localparam logic [3:0]  LOW_LINE_12    = 4'h0;
    localparam logic [3:0]  LOW_LINE_10    = 4'h2;
    localparam logic [3:0]  LOW_LINE_8     = 4'h4;
    // ---------------------------------------------------------------
    // pixel path
    // ---------------------------------------------------------------
    localparam int          PIX_W          = 12;
    localparam logic [11:0] ALL_LINES      = 12'hFFF;
    localparam logic [11:0] NO_LINES       = 12'h000;
    localparam int          LEAD_DEPTH     = 16;
    localparam logic [3:0]  LEAD_LAST      = 4'hF;
    localparam int          PKT_W          = 16;
    localparam int          PKT_VALID      = 12;
    localparam int          PKT_ROW        = 13;
    localparam int          PKT_FRAME      = 14;
    localparam int          PKT_FIELD      = 15;
    localparam int          PULSE_CNT_W    = 3;
    localparam logic [2:0]  LSYNC_PULSE    = 3'h4;
    localparam logic [2:0]  FSYNC_PULSE    = 3'h4;
endpackage

// *** hdl/sensor_clock_gen.sv ***
// master clock edge finder and sensor clock divider
`timescale 1ns/100ps
module sensor_clock_gen (
    input  wire logic       core_clk_in,
    input  wire logic       arst_n_in,
    input  wire logic       mclk_in,
    input  wire logic [7:0] divisor_in,
    output logic            sensor_tick_out
);
    import video_port_pkg::*;

    logic       mclk_meta_reg;
    logic       mclk_sync_reg;
    logic       mclk_prev_reg;
    logic [7:0] count_reg;
    logic [7:0] count_next;
    wire        mclk_rise;
    wire        count_wrap;

    // ---------------------------------------------------------------
    // edge detect and count
    // ---------------------------------------------------------------
    assign mclk_rise  = mclk_sync_reg & ~mclk_prev_reg;
    // zero and one both give one tick per master clock
    assign count_wrap = (divisor_in == 8'h00) |
                        (count_reg >= 8'(divisor_in - 8'h01));
    assign count_next = count_wrap ? 8'h00 : 8'(count_reg + 8'h01);

    always_ff @(posedge core_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            mclk_meta_reg   <= 1'b0;
            mclk_sync_reg   <= 1'b0;
            mclk_prev_reg   <= 1'b0;
            count_reg       <= 8'h00;
            sensor_tick_out <= 1'b0;
        end else begin
            mclk_meta_reg   <= mclk_in;
            mclk_sync_reg   <= mclk_meta_reg;
            mclk_prev_reg   <= mclk_sync_reg;
            sensor_tick_out <= mclk_rise & count_wrap;
            if (mclk_rise) begin
                count_reg <= count_next;
            end
        end
    end

    a_tick_needs_edge: assert property (@(posedge core_clk_in)
        disable iff (!arst_n_in)
        sensor_tick_out |-> $past(mclk_rise))
        else $error("sensor tick without master clock edge");
    a_undivided_tick: assert property (@(posedge core_clk_in)
        disable iff (!arst_n_in)
        (mclk_rise && divisor_in == 8'h00) |=> sensor_tick_out)
        else $error("zero divisor did not pass every edge");
endmodule // sensor_clock_gen

// *** hdl/pixel_delay_line.sv ***
// shift register that holds recent pixel slots for sync lead
`timescale 1ns/100ps
module pixel_delay_line #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 16
) (
    input  wire logic             core_clk_in,
    input  wire logic             arst_n_in,
    input  wire logic             shift_in,
    input  wire logic [WIDTH-1:0] data_in,
    output logic      [WIDTH-1:0] taps_out [DEPTH]
);
    // ---------------------------------------------------------------
    // one stage per pixel slot
    // ---------------------------------------------------------------
    genvar i;
    generate
        for (i = 0; i < DEPTH; i++) begin : g_stage
            wire [WIDTH-1:0] stage_src;
            if (i == 0) begin : g_head
                assign stage_src = data_in;
            end else begin : g_body
                assign stage_src = taps_out[i-1];
            end
            always_ff @(posedge core_clk_in or negedge arst_n_in) begin
                if (!arst_n_in) begin
                    taps_out[i] <= '0;
                end else if (shift_in) begin
                    taps_out[i] <= stage_src;
                end
            end
        end
    endgenerate
endmodule // pixel_delay_line

// *** sim/capture_model.sv ***
// capture side model that samples the video bus on the pixel clock
`timescale 1ns/100ps
module capture_model (
    input  wire logic        core_clk_in,
    input  wire logic        pclk_in,
    input  wire logic        edge_in,
    input  wire logic [11:0] data_in,
    output logic      [11:0] word_out
);
    logic pclk_d = 1'b0;
    // takes a word only where the pixel clock moves away from its idle level
    always @(posedge core_clk_in) begin
        pclk_d <= pclk_in;
        if (pclk_in != pclk_d && pclk_in != edge_in)
            word_out <= data_in;
    end
endmodule // capture_model

// *** sim/tb.sv ***
// self-checking bench for the video port configuration block
`timescale 1ns/100ps
module tb;
    import video_port_pkg::*;
    logic clk = 0, rst_n = 0, mclk = 0, wr = 0, vld = 1, row = 0, frm = 0;
    logic fld = 0, gb, ap, cp, tick, pc, pcoe, fs, fsoe, ls, lsoe;
    logic [7:0] addr = 8'h00, wdata = 8'h00, rdata;
    logic [11:0] adc = 12'h000, vd, voe, word;
    int n_fail = 0, check_count = 0, cyc = 0, t0, dv[3] = '{4, 3, 0};
    int model [4:8] = '{0, 4, 0, 0, 0};
    always #2.5 clk = ~clk;
    always #62.5 mclk = ~mclk;
    always @(posedge clk) begin
        cyc++;
        if (cyc == 90000) begin
            n_fail++;
            complete_run();
        end
    end
    video_port_config uut (.core_clk_in(clk), .arst_n_in(rst_n),
        .mclk_in(mclk), .reg_addr_in(addr), .reg_wdata_in(wdata),
        .reg_wr_in(wr), .reg_rdata_out(rdata), .gain_bypass_out(gb),
        .amplifier_powerdown_out(ap), .converter_powerdown_out(cp),
        .pixel_tick_out(tick), .adc_data_in(adc), .pix_valid_in(vld),
        .row_active_in(row), .frame_active_in(frm), .field_odd_in(fld),
        .video_data_out(vd), .video_data_oe_out(voe), .pclk_out(pc),
        .pclk_oe_out(pcoe), .frame_sync_out(fs), .frame_sync_oe_out(fsoe),
        .line_sync_out(ls), .line_sync_oe_out(lsoe));
    capture_model cap (.core_clk_in(clk), .pclk_in(pc),
        .edge_in(model[7][4]), .data_in(vd), .word_out(word));
    task automatic check(input logic [11:0] seen, exp);
        check_count++;
        if (seen !== exp) begin
            n_fail++;
            $display("CHECK FAILED t=%0t seen %h exp %h", $time, seen, exp);
        end
    endtask
    task automatic wr_reg(input logic [7:0] a, d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        if (a inside {[4:8]})
            model[a] = d & (a == 4 ? MASK_POWER : a[0] ? 8'hFF : MASK_FORMAT);
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic rd_chk(input logic [7:0] a);
        @(posedge clk);
        addr <= a;
        repeat (2) @(posedge clk);
        #1 check(rdata, a inside {[4:8]} ? model[a] : 0);
    endtask
    task automatic ticks(input int n);
        repeat (n) @(posedge tick);
        @(posedge clk);
        #1;
    endtask
    task automatic complete_run();
        $display("checks %0d failures %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    initial begin
        void'($urandom(81));
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        for (int p = 0; p < 2; p++) begin
            for (int a = 3; a < 10; a++) rd_chk(a);
            if (p == 0)
                for (int a = 3; a < 10; a++) wr_reg(a, $urandom);
        end
        check(gb, model[4][7]);
        check(ap, model[4][3]);
        check(cp, model[4][0]);
        $display("test registers done");
        foreach (dv[i]) begin
            wr_reg(ADDR_DIVIDER, dv[i]);
            ticks(3);
            t0 = cyc;
            ticks(1);
            check(cyc - t0, dv[i] > 1 ? 50 * dv[i] : 50);
        end
        adc <= $urandom;
        row <= 1'b1;
        frm <= 1'b1;
        for (int c = 0; c < 16; c++) begin
            wr_reg(ADDR_SYNC, $urandom & 8'h9C);
            wr_reg(ADDR_FORMAT, c << 4);
            ticks(18);
            check(vd, adc << c[1:0]);
            check(word, adc << c[1:0]);
            check(voe, c[3:2] == 3 ? 12'hFFF : 12'hFFF << 2 * c[3:2]);
            check({ls, fs}, {!model[7][2], !model[7][3]});
        end
        wr_reg(ADDR_SYNC, 8'h6C);
        row <= 1'b0;
        frm <= 1'b0;
        ticks(18);
        check({ls, fs}, 2'b00);
        ticks(4);
        check({ls, fs}, 2'b11);
        wr_reg(ADDR_SYNC, 8'h02);
        fld <= $urandom;
        ticks(18);
        check(fs, fld);
        vld <= 1'b0;
        for (int e = 0; e < 2; e++) begin
            wr_reg(ADDR_SYNC, e ? 8'h90 : 8'h80);
            ticks(18);
            repeat (30) @(posedge clk);
            #1 check(pc, e[0]);
        end
        wr_reg(ADDR_SYNC, 8'h01);
        repeat (3) @(posedge clk);
        #1 check(voe, 0);
        check({pcoe, fsoe, lsoe}, 0);
        // level mode, row rises: line sync must lead the data by the lead
        wr_reg(ADDR_SYNC, 8'h00);
        wr_reg(ADDR_LEAD, $urandom);
        row <= 1'b1;
        ticks(16 - model[8][7:4]);
        check(ls, 0);
        ticks(1);
        check(ls, 1);
        $display("test video port done");
        complete_run();
    end
endmodule // tb
